/* rtl/video_test_pattern_select.v */
// Purpose: test pattern select and colour generation ahead of the serial datapath
// Assumes: pixel stream and register port run on mclk; no synchronisers needed
// Notes: custom levels and scroll frame count arrive as plain inputs
`timescale 1ns/1ps
`default_nettype none
`include "pattern_map.vh"
module video_test_pattern_select #(
	parameter H_ACTIVE = `H_ACTIVE_DEF,
	parameter V_ACTIVE = `V_ACTIVE_DEF,
	parameter POS_W = 12
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	input wire ce,
	// register port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// pattern settings
	input wire [7:0] custom_red_level,
	input wire [7:0] custom_green_level,
	input wire [7:0] custom_blue_level,
	input wire [7:0] scroll_frame_count,
	// parallel pixel input
	input wire pix_valid,
	output wire pix_ready,
	input wire [23:0] pix_rgb,
	input wire pix_de,
	input wire pix_hs,
	input wire pix_vs,
	// serial datapath side
	output wire out_valid,
	input wire out_ready,
	output wire [23:0] out_rgb,
	output wire out_de,
	output wire out_hs,
	output wire out_vs,
	output reg [3:0] active_sel
);
	reg [7:0] pat_ctrl;
	reg [7:0] pat_cfg;
	reg [POS_W-1:0] hpos;
	reg [POS_W-1:0] vpos;
	reg last_de;
	reg last_vs;
	reg [7:0] frame_cnt;
	reg [3:0] scroll_sel;
	reg [23:0] gen_rgb;
	reg [7:0] lvl;
	reg [23:0] mask;
	reg is_ramp;
	reg gray;
	wire take;
	wire frame_start;
	wire line_end;
	wire inv;
	wire [3:0] sel_now;
	wire [23:0] buf_rgb;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] ramp_level;
		input [POS_W-1:0] pos;
		input [POS_W:0] span;
		reg [POS_W+8:0] prod;
		begin
			prod = {1'b0, pos, 8'h00} / {8'h00, span};
			if (prod > 255) begin
				ramp_level = 8'hFF;
			end else begin
				ramp_level = prod[7:0];
			end
		end
	endfunction

	function [23:0] grey;
		input [7:0] v;
		begin
			grey = {v, v, v};
		end
	endfunction

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pat_ctrl <= `RST_PAT_CTRL;
			pat_cfg <= `RST_PAT_CFG;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_wr && reg_addr == `ADDR_PAT_CTRL) begin
				pat_ctrl <= {reg_wdata[7:4], 3'b000, reg_wdata[0]};
			end
			if (reg_wr && reg_addr == `ADDR_PAT_CFG) begin
				pat_cfg <= {3'b000, reg_wdata[4:0]};
			end
			if (reg_rd) begin
				case (reg_addr)
					`ADDR_PAT_CTRL: reg_rdata <= pat_ctrl;
					`ADDR_PAT_CFG: reg_rdata <= pat_cfg;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// position tracking
	// ----------------------------------------
	assign take = pix_valid & pix_ready & ce;
	assign frame_start = pix_vs & ~last_vs;
	assign line_end = ~pix_de & last_de;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hpos <= {POS_W{1'b0}};
			vpos <= {POS_W{1'b0}};
			last_de <= 1'b0;
			last_vs <= 1'b0;
		end else if (take) begin
			last_de <= pix_de;
			last_vs <= pix_vs;
			if (pix_de) begin
				hpos <= hpos + 1'b1;
			end else begin
				hpos <= {POS_W{1'b0}};
			end
			if (frame_start) begin
				vpos <= {POS_W{1'b0}};
			end else if (line_end) begin
				vpos <= vpos + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// auto scroll
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_cnt <= 8'h00;
			scroll_sel <= `SEL_FIRST;
		end else if (take && frame_start) begin
			if (!pat_cfg[`CFG_SCROLL_BIT]) begin
				frame_cnt <= 8'h00;
			end else if (frame_cnt + 8'h01 >= scroll_frame_count) begin
				frame_cnt <= 8'h00;
				if (scroll_sel == `SEL_LAST) begin
					scroll_sel <= `SEL_FIRST;
				end else begin
					scroll_sel <= scroll_sel + 4'h1;
				end
			end else begin
				frame_cnt <= frame_cnt + 8'h01;
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active_sel <= 4'h0;
		end else if (ce) begin
			active_sel <= sel_now;
		end
	end

	// ----------------------------------------
	// pattern generation
	// ----------------------------------------
	assign sel_now = pat_cfg[`CFG_SCROLL_BIT] ? scroll_sel :
		pat_ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];
	assign inv = pat_cfg[`CFG_INV_BIT];

	always @* begin
		lvl = 8'h00;
		mask = 24'h000000;
		is_ramp = 1'b0;
		gray = 1'b0;
		gen_rgb = 24'h000000;
		case (sel_now)
			`SEL_WHITE: gen_rgb = 24'hFFFFFF;
			`SEL_BLACK: gen_rgb = 24'h000000;
			`SEL_RED: gen_rgb = 24'hFF0000;
			`SEL_GREEN: gen_rgb = 24'h00FF00;
			`SEL_BLUE: gen_rgb = 24'h0000FF;
			`SEL_H_WHITE, `SEL_H_RED, `SEL_H_GREEN, `SEL_H_BLUE: begin
				is_ramp = 1'b1;
				lvl = ramp_level(hpos, H_ACTIVE[POS_W:0]);
			end
			`SEL_V_WHITE, `SEL_V_RED, `SEL_V_GREEN, `SEL_V_BLUE: begin
				is_ramp = 1'b1;
				lvl = ramp_level(vpos, V_ACTIVE[POS_W:0]);
			end
			`SEL_CUSTOM: gen_rgb = {custom_red_level, custom_green_level, custom_blue_level};
			default: gen_rgb = 24'h000000;
		endcase
		case (sel_now)
			`SEL_H_WHITE, `SEL_V_WHITE: begin
				mask = 24'hFFFFFF;
				gray = 1'b1;
			end
			`SEL_H_RED, `SEL_V_RED: mask = 24'hFF0000;
			`SEL_H_GREEN, `SEL_V_GREEN: mask = 24'h00FF00;
			`SEL_H_BLUE, `SEL_V_BLUE: mask = 24'h0000FF;
			default: mask = 24'h000000;
		endcase
		if (pat_cfg[`CFG_18BIT_BIT]) begin
			lvl = lvl & 8'hFC;
		end
		if (is_ramp) begin
			if (inv && !gray) begin
				gen_rgb = ~(grey(8'hFF - lvl) & mask);
			end else begin
				gen_rgb = grey(lvl) & mask;
			end
		end
		if (inv && !(is_ramp && !gray)) begin
			gen_rgb = ~gen_rgb;
		end
		if (!pat_ctrl[`CTRL_EN_BIT]) begin
			gen_rgb = pix_rgb;
		end
	end

	// ----------------------------------------
	// output buffer
	// ----------------------------------------
	pixel_skid_buffer #(
		.WIDTH(27)
	) u_buf (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(pix_valid),
		.in_ready(pix_ready),
		.in_data({gen_rgb, pix_de, pix_hs, pix_vs}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data({buf_rgb, out_de, out_hs, out_vs})
	);
	assign out_rgb = buf_rgb;
endmodule
`default_nettype wire

/* rtl/pattern_map.vh */
// Purpose: constants for the video test pattern select block
// Assumes: included by bare name from the video_test_pattern_select module only
// Notes: offsets are serial control bus register addresses
`ifndef PATTERN_MAP_VH
`define PATTERN_MAP_VH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define ADDR_PAT_CTRL 8'h64
`define ADDR_PAT_CFG 8'h65
`define RST_PAT_CTRL 8'h10
`define RST_PAT_CFG 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_SEL_HI 7
`define CTRL_SEL_LO 4
`define CTRL_EN_BIT 0
`define CFG_18BIT_BIT 4
`define CFG_INV_BIT 1
`define CFG_SCROLL_BIT 0

// ----------------------------------------
// select codes
// ----------------------------------------
`define SEL_WHITE 4'h1
`define SEL_BLACK 4'h2
`define SEL_RED 4'h3
`define SEL_GREEN 4'h4
`define SEL_BLUE 4'h5
`define SEL_H_WHITE 4'h6
`define SEL_H_RED 4'h7
`define SEL_H_GREEN 4'h8
`define SEL_H_BLUE 4'h9
`define SEL_V_WHITE 4'hA
`define SEL_V_RED 4'hB
`define SEL_V_GREEN 4'hC
`define SEL_V_BLUE 4'hD
`define SEL_CUSTOM 4'hE
`define SEL_FIRST 4'h1
`define SEL_LAST 4'hE

// ----------------------------------------
// timing defaults
// ----------------------------------------
`define H_ACTIVE_DEF 1920
`define V_ACTIVE_DEF 720

`endif

/* rtl/pixel_skid_buffer.v */
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, source and sink on mclk
// Notes: out_data and in_ready come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module pixel_skid_buffer #(
	parameter WIDTH = 27
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	input wire ce,
	// fill side
	input wire in_valid,
	output reg in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output reg out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);
	reg skid_valid;
	reg [WIDTH-1:0] skid_data;
	wire take;
	wire drain;

	assign take = in_valid & in_ready;
	assign drain = out_ready | ~out_valid;

	// ----------------------------------------
	// entry movement
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			skid_valid <= 1'b0;
			skid_data <= {WIDTH{1'b0}};
			in_ready <= 1'b1;
		end else if (ce) begin
			if (drain) begin
				if (skid_valid) begin
					out_valid <= 1'b1;
					out_data <= skid_data;
					skid_valid <= 1'b0;
					in_ready <= 1'b1;
				end else begin
					out_valid <= take;
					if (take) begin
						out_data <= in_data;
					end
				end
			end else if (take) begin
				skid_valid <= 1'b1;
				skid_data <= in_data;
				in_ready <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/pixel_sink.sv */
// Purpose: stand-in for the serial datapath taking output pixels
// Assumes: single mclk domain
// Notes: slow makes it refuse most cycles
`timescale 1ns/1ps
`default_nettype none
module pixel_sink (
	// clock
	input wire logic mclk,
	input wire logic rst_n,
	// handshake
	input wire logic slow,
	output logic out_ready
);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) out_ready <= 0;
		else out_ready <= slow ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
	end
endmodule
`default_nettype wire

/* tb/video_test_pattern_select_checker.sv */
// Purpose: port checks for video_test_pattern_select
// Assumes: single mclk domain
// Notes: shadows follow register writes
`timescale 1ns/1ps
`default_nettype none
module video_test_pattern_select_checker (
	// clock
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// bus
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// stream
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire logic pix_vs,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [23:0] out_rgb,
	input wire logic [3:0] active_sel
);
	logic [7:0] ctrl_s;
	logic [7:0] cfg_s;
	logic armed;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_s <= 8'h10;
			cfg_s <= 8'h00;
		end else if (ce && reg_wr && reg_addr == 8'h64) begin
			ctrl_s <= reg_wdata;
		end else if (ce && reg_wr && reg_addr == 8'h65) begin
			cfg_s <= reg_wdata;
		end
	end
	// set one edge after reset release, so the select check skips the reset edge
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence rd(a);
		ce && reg_rd && reg_addr == a;
	endsequence
	sequence quiet;
		(ce && cfg_s[0] && !pix_vs)[*5];
	endsequence
	AST_CTRL_RD: assert property (rd(8'h64) |=> reg_rdata == (ctrl_s & 8'hF1))
		else $error("ctrl readback");
	AST_CFG_RD: assert property (rd(8'h65) |=> reg_rdata == (cfg_s & 8'h1F))
		else $error("cfg readback");
	AST_SEL: assert property ((ce && armed && !cfg_s[0] && $stable(ctrl_s))[*2] |-> active_sel == ctrl_s[7:4])
		else $error("select not applied");
	AST_SCROLL: assert property (quiet |-> $stable(active_sel))
		else $error("select moved without frame");
	AST_HOLD: assert property (out_valid && !(ce && out_ready) |=> out_valid && $stable(out_rgb))
		else $error("output dropped");
	AST_TAKE: assert property (ce && pix_valid && pix_ready |=> out_valid)
		else $error("no output after take");
	AST_FULL: assert property ($fell(pix_ready) |-> $past(out_valid && !(ce && out_ready)))
		else $error("refused without stall");
	AST_RDY: assert property (!pix_ready && ce && out_ready |=> pix_ready)
		else $error("ready not restored");
endmodule
bind video_test_pattern_select video_test_pattern_select_checker u_chk (.*);
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench for video_test_pattern_select
// Assumes: pixel_sink stalls the output side
// Notes: 6x4 active area keeps frames short; height of 4 makes vertical ramp levels whole
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk, rst_n, ce, reg_wr, reg_rd, pix_valid, pix_de, pix_hs, pix_vs, slow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, scroll_frame_count;
	logic [7:0] custom_red_level, custom_green_level, custom_blue_level;
	logic [23:0] pix_rgb, out_rgb;
	logic pix_ready, out_valid, out_ready, out_de, out_hs, out_vs, inv, en, sc, b18;
	logic [3:0] active_sel, sel, a;
	logic [53:0] e;
	logic [53:0] q[$];
	int error_cnt, checks;
	localparam int HA = 6;
	localparam int VA = 4;
	video_test_pattern_select #(.H_ACTIVE(HA), .V_ACTIVE(VA)) u_video_test_pattern_select (.*);
	pixel_sink u_pixel_sink (.*);
	// ------
	// tasks
	// ------
	task automatic chk(input logic [26:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] ad, d);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= ad;
		reg_wdata <= d;
		do @(posedge mclk); while (!ce);
		reg_wr <= 0;
		reg_rd <= 0;
		#1 if (!w) chk(reg_rdata, d);
	endtask
	function automatic logic [23:0] pat(input logic [3:0] s, input logic [7:0] h, v);
		logic [23:0] m, r;
		logic [7:0] l;
		m = s % 4 == 3 ? 24'hFF0000 : s % 4 == 0 ? 24'h00FF00 : s % 4 == 1 && s != 1 ? 24'h0000FF : 24'hFFFFFF;
		l = s > 9 ? 8'(v * 256 / VA) : 8'(h * 256 / HA);
		if (b18) l = l & 8'hFC;
		if (s == 14) r = {custom_red_level, custom_green_level, custom_blue_level};
		else if (s < 6) r = s == 2 ? 24'h0 : m;
		else if (inv && m != 24'hFFFFFF) return ~(m & ~{l, l, l});
		else r = m & {l, l, l};
		return inv ? ~r : r;
	endfunction
	task automatic px(input logic de, vs, input logic [7:0] h, v);
		logic [23:0] r;
		r = $urandom;
		pix_valid <= 1;
		pix_de <= de;
		pix_hs <= !de;
		pix_vs <= vs;
		pix_rgb <= r;
		do @(posedge mclk); while (!(ce && pix_ready));
		q.push_back({3'h7, en && !de || sc ? 24'h0 : 24'hFFFFFF, de, !de, vs, en ? pat(sel, h, v) : r});
	endtask
	task automatic frame;
		repeat (3) @(posedge mclk);
		px(0, 1, 0, 0);
		for (logic [7:0] v = 0; v < VA; v++) begin
			for (logic [7:0] h = 0; h < HA; h++) px(1, 0, h, v);
			px(0, 0, 0, 0);
		end
		pix_valid <= 0;
		repeat (300) if (q.size() != 0) @(posedge mclk);
		#1;
	endtask
	always @(posedge mclk) begin
		ce <= $urandom % 8 != 0;
		if (rst_n && ce && out_valid && out_ready) begin
			e = q.size() != 0 ? q.pop_front() : '1;
			chk({out_de, out_hs, out_vs, out_rgb} & e[53:27], e[26:0] & e[53:27]);
		end
	end
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#400000;
		error_cnt++;
		complete_run;
	end
	initial begin
		void'($urandom(32'h4C7A));
		{reg_wr, reg_rd, pix_valid, pix_de, pix_hs, pix_vs, slow, sc, b18, rst_n} = 0;
		{reg_addr, reg_wdata, pix_rgb, scroll_frame_count} = 0;
		{custom_red_level, custom_green_level, custom_blue_level} = 0;
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		bus(0, 8'h64, 8'h10);
		bus(0, 8'h65, 8'h00);
		bus(0, 8'h66, 8'h00);
		bus(1, 8'h64, 8'hEF);
		bus(0, 8'h64, 8'hE1);
		bus(1, 8'h65, 8'hFF);
		bus(0, 8'h65, 8'h1F);
		for (int k = 0; k < 30; k++) begin
			sel = 4'(k % 15);
			inv = k > 14;
			en = sel != 0;
			b18 = k % 4 == 3;
			slow <= k % 4 == 1;
			{custom_red_level, custom_green_level, custom_blue_level} <= $urandom;
			bus(1, 8'h65, {3'h0, b18, 2'h0, inv, 1'b0});
			bus(1, 8'h64, {en ? sel : 4'h1, 3'h0, en});
			frame;
		end
		sc = 1;
		inv = 0;
		scroll_frame_count <= 1;
		bus(1, 8'h65, 8'h01);
		repeat (3) begin
			bus(1, 8'h64, {4'($urandom_range(14, 1)), 4'h1});
			a = active_sel;
			frame;
			chk(active_sel, a % 14 + 1);
		end
		scroll_frame_count <= 3;
		a = active_sel;
		repeat (2) frame;
		chk(active_sel, a);
		frame;
		chk(active_sel, a % 14 + 1);
		chk(27'(q.size()), 27'h0);
		complete_run;
	end
endmodule
`default_nettype wire
